// [logic/atc_trigger_ctrl.sv]
/*
 * Acquisition trigger and timing controller with its APB register file.
 * Assumes a single 250 MHz clock; all far-side pins are asynchronous and are
 * resynchronised here. A sample takes place on each rising edge of the chosen
 * conversion clock in the arm and acquire states, and while waiting in pre and middle modes.
 */
`timescale 1ns/1ns
module atc_trigger_ctrl (
	// Clock and reset.
	input  wire logic                I_CLOCK,
	input  wire logic                I_RST_N,
	// APB slave.
	input  wire logic                I_PSEL,
	input  wire logic                I_PENABLE,
	input  wire logic                I_PWRITE,
	input  wire logic [7:0]          I_PADDR,
	input  wire logic [31:0]         I_PWDATA,
	output logic      [31:0]         O_PRDATA,
	output logic                     O_PREADY,
	output logic                     O_PSLVERR,
	// Far-side pins and front end.
	input  wire atc_pkg::atc_pins_t  I_PINS,
	output atc_pkg::atc_front_t      O_FRONT,
	output logic                     O_RUNNING
);
	import atc_pkg::*;

	// Synchroniser stages and edge history.
	atc_pins_t pin_meta_reg, pin_sync_reg, pin_last_reg;
	atc_pins_t pin_meta_next, pin_sync_next, pin_last_next;

	// Configuration state.
	logic [31:0] trig_reg, trig_next, cfg_reg, cfg_next;
	logic [23:0] post_reg, post_next, total_reg, total_next;
	logic [15:0] pre_reg, pre_next, retrig_reg, retrig_next;
	logic [3:0]  range_reg [ATC_NUM_CH];
	logic [3:0]  range_next [ATC_NUM_CH];
	logic [7:0]  rd_chan_reg, rd_chan_next;
	logic [31:0] prdata_reg, prdata_next;

	// Run state.
	atc_state_t  state_reg, state_next;
	logic [23:0] cnt_reg, cnt_next;
	logic [15:0] trg_cnt_reg, trg_cnt_next;
	logic        swtrig_reg, swtrig_next;
	logic        done_reg, done_next;
	logic        sample_reg, sample_next, store_reg, store_next;

	// Decoded fields.
	atc_mode_t     mode;
	atc_trg_src_t  tsrc;
	atc_conv_src_t csrc;
	atc_dly_src_t  dsrc;
	logic          wr_en, rd_en, start_cmd, stop_cmd, conv_tick, dly_tick, trig_evt, retrig_ok;
	logic          tick_int;

	// Rising edge of one synchronised pin; shared by several decoders.
	function automatic logic rise(input logic now, input logic last);
		rise = now & ~last;
	endfunction

	// Register address match within the APB access phase.
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction

	assign mode      = atc_mode_t'(trig_reg[ATC_TRG_MODE_LSB +: 2]);
	assign tsrc      = atc_trg_src_t'(trig_reg[ATC_TRG_SRC_LSB +: 2]);
	assign csrc      = atc_conv_src_t'(cfg_reg[ATC_CFG_CONV_LSB +: 2]);
	assign dsrc      = atc_dly_src_t'(cfg_reg[ATC_CFG_DLY_LSB +: 2]);
	assign wr_en     = I_PSEL & I_PENABLE & I_PWRITE;
	assign rd_en     = I_PSEL & ~I_PENABLE & ~I_PWRITE;
	assign start_cmd = wr_en & hit(I_PADDR, ATC_OFS_CMD) & I_PWDATA[ATC_CMD_START];
	assign stop_cmd  = wr_en & hit(I_PADDR, ATC_OFS_CMD) & I_PWDATA[ATC_CMD_STOP];
	// The internal timer ticks every clock; the rate divider lives upstream.
	assign tick_int  = 1'b1;

	// Synchronisers: only the second stage and the edge history feed logic.
	always_comb begin
		pin_meta_next = I_PINS;
		pin_sync_next = pin_meta_reg;
		pin_last_next = pin_sync_reg;
	end

	// Source multiplexers and trigger qualification.
	always_comb begin
		unique case (csrc)
			ATC_CONV_AUX0: conv_tick = rise(pin_sync_reg.aux0, pin_last_reg.aux0);
			ATC_CONV_SYNC: conv_tick = rise(pin_sync_reg.sync_clk, pin_last_reg.sync_clk);
			ATC_CONV_AUX1: conv_tick = rise(pin_sync_reg.aux1, pin_last_reg.aux1);
			default:       conv_tick = tick_int;
		endcase
		unique case (dsrc)
			ATC_DLY_AUX1: dly_tick = rise(pin_sync_reg.aux1, pin_last_reg.aux1);
			ATC_DLY_GPT0: dly_tick = rise(pin_sync_reg.gpt0, pin_last_reg.gpt0);
			ATC_DLY_GPT1: dly_tick = rise(pin_sync_reg.gpt1, pin_last_reg.gpt1);
			default:      dly_tick = tick_int;
		endcase
		unique case (tsrc)
			ATC_TRG_ANALOG:   trig_evt = rise(pin_sync_reg.ana_trig, pin_last_reg.ana_trig);
			ATC_TRG_EXTERNAL: trig_evt = trig_reg[ATC_TRG_FALLING]
				? rise(pin_last_reg.ext_trig, pin_sync_reg.ext_trig)
				: rise(pin_sync_reg.ext_trig, pin_last_reg.ext_trig);
			ATC_TRG_SYNCBUS:  trig_evt = rise(pin_sync_reg.sync_trig, pin_last_reg.sync_trig);
			default:          trig_evt = swtrig_reg;
		endcase
		retrig_ok = trig_reg[ATC_TRG_RETRIG] & (mode == ATC_MODE_POST || mode == ATC_MODE_DELAY);
	end

	// Register file writes and read data.
	always_comb begin
		trig_next   = trig_reg;
		cfg_next    = cfg_reg;
		post_next   = post_reg;
		pre_next    = pre_reg;
		retrig_next = retrig_reg;
		total_next  = total_reg;
		rd_chan_next = rd_chan_reg;
		swtrig_next = wr_en & hit(I_PADDR, ATC_OFS_CMD) & I_PWDATA[ATC_CMD_SWTRIG];
		for (int i = 0; i < ATC_NUM_CH; i++) begin
			range_next[i] = range_reg[i];
		end
		prdata_next = prdata_reg;
		if (wr_en && state_reg == ATC_ST_IDLE) begin
			// Configuration is frozen while running so one mode holds per acquisition.
			case (I_PADDR)
				ATC_OFS_CONFIG:  cfg_next    = {26'h0, I_PWDATA[5:0]};
				ATC_OFS_TRIG:    trig_next   = {24'h0, I_PWDATA[7:0]};
				ATC_OFS_POSTCNT: post_next   = I_PWDATA[ATC_POST_W-1:0];
				ATC_OFS_PRECNT:  pre_next    = I_PWDATA[ATC_DLY_W-1:0];
				ATC_OFS_RETRIG:  retrig_next = I_PWDATA[ATC_DLY_W-1:0];
				ATC_OFS_TOTAL:   total_next  = I_PWDATA[ATC_POST_W-1:0];
				ATC_OFS_RANGERD: rd_chan_next = I_PWDATA[7:0];
				ATC_OFS_RANGE: begin
					for (int i = 0; i < ATC_NUM_CH; i++) begin
						if (I_PWDATA[7:0] == ATC_ALL_CHANNELS || I_PWDATA[7:0] == 8'(i)) begin
							range_next[i] = I_PWDATA[ATC_RNG_CODE_LSB +: 4];
						end
					end
				end
				default: ;
			endcase
		end
		if (rd_en) begin
			case (I_PADDR)
				ATC_OFS_CONFIG:  prdata_next = cfg_reg;
				ATC_OFS_TRIG:    prdata_next = trig_reg;
				ATC_OFS_POSTCNT: prdata_next = {8'h0, post_reg};
				ATC_OFS_PRECNT:  prdata_next = {16'h0, pre_reg};
				ATC_OFS_RETRIG:  prdata_next = {16'h0, retrig_reg};
				ATC_OFS_TOTAL:   prdata_next = {8'h0, total_reg};
				ATC_OFS_STATUS:  prdata_next = {trg_cnt_reg, 9'h0, done_reg, 1'b0, state_reg};
				ATC_OFS_RANGERD: prdata_next = {24'h0, rd_chan_reg};
				ATC_OFS_RANGE:   prdata_next = {28'h0, range_reg[rd_chan_reg[1:0]]};
				default:         prdata_next = 32'h0;
			endcase
		end
	end

	// Acquisition sequencer.
	always_comb begin
		state_next   = state_reg;
		cnt_next     = cnt_reg;
		trg_cnt_next = trg_cnt_reg;
		done_next    = done_reg;
		sample_next  = 1'b0;
		store_next   = 1'b0;
		case (state_reg)
			ATC_ST_IDLE: begin
				if (start_cmd) begin
					done_next    = 1'b0;
					trg_cnt_next = 16'h0;
					cnt_next     = {8'h0, pre_reg};
					// Pre-trigger counter only applies to pre and middle modes.
					if ((mode == ATC_MODE_PRE || mode == ATC_MODE_MIDDLE)
						&& trig_reg[ATC_TRG_PRECNT_EN]) begin
						state_next = ATC_ST_ARM;
					end else begin
						state_next = ATC_ST_WAIT;
					end
				end
			end
			ATC_ST_ARM: begin
				// Sampling already runs; triggers are dropped until terminal count.
				sample_next = conv_tick;
				store_next  = conv_tick;
				if (conv_tick) begin
					if (cnt_reg == 24'h0) begin
						state_next = ATC_ST_WAIT;
					end else begin
						cnt_next = cnt_reg - 24'h1;
					end
				end
			end
			ATC_ST_WAIT: begin
				// Pre and middle modes keep filling the circular store while waiting.
				if (mode == ATC_MODE_PRE || mode == ATC_MODE_MIDDLE) begin
					sample_next = conv_tick;
					store_next  = conv_tick;
				end
				if (trig_evt) begin
					trg_cnt_next = trg_cnt_reg + 16'h1;
					unique case (mode)
						ATC_MODE_PRE: begin
							state_next = ATC_ST_IDLE;
							done_next  = 1'b1;
						end
						ATC_MODE_DELAY: begin
							state_next = ATC_ST_DLY;
							cnt_next   = {8'h0, post_reg[ATC_DLY_W-1:0]};
						end
						default: begin
							state_next = ATC_ST_ACQ;
							cnt_next   = post_reg;
						end
					endcase
				end
			end
			ATC_ST_DLY: begin
				// Discarded period: samples or ticks, chosen per acquisition.
				if (trig_reg[ATC_TRG_DLYSMP] ? conv_tick : dly_tick) begin
					if (cnt_reg == 24'h0) begin
						state_next = ATC_ST_ACQ;
						cnt_next   = total_reg;
					end else begin
						cnt_next = cnt_reg - 24'h1;
					end
				end
			end
			ATC_ST_ACQ: begin
				sample_next = conv_tick;
				store_next  = conv_tick;
				if (conv_tick) begin
					if (cnt_reg <= 24'h1) begin
						// Segment ends; zero accepted count keeps re-arming forever.
						if (retrig_ok && (retrig_reg == 16'h0 || trg_cnt_reg < retrig_reg)) begin
							state_next = ATC_ST_WAIT;
						end else begin
							state_next = ATC_ST_IDLE;
							done_next  = 1'b1;
						end
					end
					cnt_next = cnt_reg - 24'h1;
				end
			end
			default: state_next = ATC_ST_IDLE;
		endcase
		if (stop_cmd && state_reg != ATC_ST_IDLE) begin
			state_next = ATC_ST_IDLE;
			done_next  = 1'b1;
		end
	end

	// State registers.
	always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			pin_meta_reg <= '0;
			pin_sync_reg <= '0;
			pin_last_reg <= '0;
			trig_reg     <= 32'h0;          // Software, post mode, ticks, rising edge.
			cfg_reg      <= 32'h0;          // Internal clocks, referenced single-ended.
			post_reg     <= 24'h0;
			pre_reg      <= 16'h0;
			retrig_reg   <= 16'h0;
			total_reg    <= 24'h0;
			rd_chan_reg  <= 8'h0;
			prdata_reg   <= 32'h0;
			for (int i = 0; i < ATC_NUM_CH; i++) begin
				range_reg[i] <= ATC_RANGE_B10V;
			end
			state_reg    <= ATC_ST_IDLE;
			cnt_reg      <= 24'h0;
			trg_cnt_reg  <= 16'h0;
			swtrig_reg   <= 1'b0;
			done_reg     <= 1'b0;
			sample_reg   <= 1'b0;
			store_reg    <= 1'b0;
		end else begin
			pin_meta_reg <= pin_meta_next;
			pin_sync_reg <= pin_sync_next;
			pin_last_reg <= pin_last_next;
			trig_reg     <= trig_next;
			cfg_reg      <= cfg_next;
			post_reg     <= post_next;
			pre_reg      <= pre_next;
			retrig_reg   <= retrig_next;
			total_reg    <= total_next;
			rd_chan_reg  <= rd_chan_next;
			prdata_reg   <= prdata_next;
			range_reg    <= range_next;
			state_reg    <= state_next;
			cnt_reg      <= cnt_next;
			trg_cnt_reg  <= trg_cnt_next;
			swtrig_reg   <= swtrig_next;
			done_reg     <= done_next;
			sample_reg   <= sample_next;
			store_reg    <= store_next;
		end
	end

	// Outputs.
	assign O_PRDATA       = prdata_reg;
	assign O_PREADY       = 1'b1;     // Zero wait states; read data is latched in setup.
	assign O_PSLVERR      = 1'b0;
	assign O_RUNNING      = (state_reg != ATC_ST_IDLE);
	assign O_FRONT.sample = sample_reg;
	assign O_FRONT.store  = store_reg;
	assign O_FRONT.ground = atc_gnd_t'(cfg_reg[ATC_CFG_GND_LSB +: 2]);
	assign O_FRONT.range0 = range_reg[0];
	assign O_FRONT.range1 = range_reg[1];
	assign O_FRONT.range2 = range_reg[2];
	assign O_FRONT.range3 = range_reg[3];

endmodule

// [shared/atc_pkg.sv]
/*
 * Package for the acquisition trigger controller: register map, field layouts,
 * mode, source and state encodings, and the packed structs that group the pins.
 * Assumes a 32-bit APB slave with word-aligned registers.
 */
package atc_pkg;

	// Register byte addresses.
	localparam logic [7:0] ATC_OFS_CONFIG  = 8'h00;
	localparam logic [7:0] ATC_OFS_TRIG    = 8'h04;
	localparam logic [7:0] ATC_OFS_POSTCNT = 8'h08;
	localparam logic [7:0] ATC_OFS_PRECNT  = 8'h0c;
	localparam logic [7:0] ATC_OFS_RETRIG  = 8'h10;
	localparam logic [7:0] ATC_OFS_TOTAL   = 8'h14;
	localparam logic [7:0] ATC_OFS_CMD     = 8'h18;
	localparam logic [7:0] ATC_OFS_STATUS  = 8'h1c;
	localparam logic [7:0] ATC_OFS_RANGE   = 8'h20;
	localparam logic [7:0] ATC_OFS_RANGERD = 8'h24;

	// Field positions in the trigger control register.
	localparam int ATC_TRG_SRC_LSB   = 0;
	localparam int ATC_TRG_MODE_LSB  = 2;
	localparam int ATC_TRG_DLYSMP    = 4;
	localparam int ATC_TRG_RETRIG    = 5;
	localparam int ATC_TRG_PRECNT_EN = 6;
	localparam int ATC_TRG_FALLING   = 7;
	// Field positions in the configuration register.
	localparam int ATC_CFG_CONV_LSB  = 0;
	localparam int ATC_CFG_DLY_LSB   = 2;
	localparam int ATC_CFG_GND_LSB   = 4;
	// Command bits.
	localparam int ATC_CMD_START     = 0;
	localparam int ATC_CMD_STOP      = 1;
	localparam int ATC_CMD_SWTRIG    = 2;
	// Range write: channel in [7:0] (8'hff means every channel), code in [11:8].
	localparam int           ATC_RNG_CODE_LSB = 8;
	localparam logic [7:0]   ATC_ALL_CHANNELS = 8'hff;
	localparam int           ATC_NUM_CH       = 4;
	localparam logic [3:0]   ATC_RANGE_B10V   = 4'h0;

	// Widths of the counters.
	localparam int ATC_DLY_W  = 16;
	localparam int ATC_POST_W = 24;

	// Conversion clock sources.
	typedef enum logic [1:0] {
		ATC_CONV_INTERNAL = 2'h0,
		ATC_CONV_AUX0     = 2'h1,
		ATC_CONV_SYNC     = 2'h2,
		ATC_CONV_AUX1     = 2'h3
	} atc_conv_src_t;

	// Delay counter clock sources.
	typedef enum logic [1:0] {
		ATC_DLY_INTERNAL = 2'h0,
		ATC_DLY_AUX1     = 2'h1,
		ATC_DLY_GPT0     = 2'h2,
		ATC_DLY_GPT1     = 2'h3
	} atc_dly_src_t;

	// Trigger sources.
	typedef enum logic [1:0] {
		ATC_TRG_SOFTWARE = 2'h0,
		ATC_TRG_ANALOG   = 2'h1,
		ATC_TRG_EXTERNAL = 2'h2,
		ATC_TRG_SYNCBUS  = 2'h3
	} atc_trg_src_t;

	// Trigger modes.
	typedef enum logic [1:0] {
		ATC_MODE_POST   = 2'h0,
		ATC_MODE_DELAY  = 2'h1,
		ATC_MODE_PRE    = 2'h2,
		ATC_MODE_MIDDLE = 2'h3
	} atc_mode_t;

	// Input grounding.
	typedef enum logic [1:0] {
		ATC_GND_RSE  = 2'h0,
		ATC_GND_DIFF = 2'h1,
		ATC_GND_NRSE = 2'h2
	} atc_gnd_t;

	// Controller states, one-hot.
	typedef enum logic [4:0] {
		ATC_ST_IDLE = 5'h01,
		ATC_ST_ARM  = 5'h02,
		ATC_ST_WAIT = 5'h04,
		ATC_ST_DLY  = 5'h08,
		ATC_ST_ACQ  = 5'h10
	} atc_state_t;

	// Asynchronous pins from the far side.
	typedef struct packed {
		logic aux0;
		logic aux1;
		logic sync_clk;
		logic gpt0;
		logic gpt1;
		logic ana_trig;
		logic ext_trig;
		logic sync_trig;
	} atc_pins_t;

	// Conversion front-end controls.
	typedef struct packed {
		logic       sample;
		logic       store;
		atc_gnd_t   ground;
		logic [3:0] range0;
		logic [3:0] range1;
		logic [3:0] range2;
		logic [3:0] range3;
	} atc_front_t;

endpackage

// [verification/atc_far_model.sv]
/*
 * Far-side model: trigger pins, timer outputs and external conversion clocks.
 * Assumes its tasks are called from one bench process just after a clock edge.
 */
`timescale 1ns/1ns
module atc_far_model (
	// Pacing clock.
	input  wire logic          i_clock,
	// Pins towards the controller.
	output atc_pkg::atc_pins_t o_pins
);
	import atc_pkg::*;

	// Every line idles low and stands still unless a task moves it.
	initial o_pins = '0;

	// A pulse long enough for the synchroniser to see both edges.
	task automatic pulse(input int idx);
		@(posedge i_clock);
		o_pins[idx] <= 1'b1;
		repeat (4) @(posedge i_clock);
		o_pins[idx] <= 1'b0;
		repeat (4) @(posedge i_clock);
	endtask

	// A single level change, so each edge can be judged on its own.
	task automatic level(input int idx, input logic v);
		@(posedge i_clock);
		o_pins[idx] <= v;
	endtask
endmodule

// [verification/atc_trigger_ctrl_assertions.sv]
/*
 * Checker for the acquisition trigger controller, bound to its top module.
 * Assumes one clock domain and the zero-wait APB answer of the design.
 */
`timescale 1ns/1ns
module atc_trigger_ctrl_assertions
	import atc_pkg::*;
(
	// Clock and reset.
	input wire logic         I_CLOCK,
	input wire logic         I_RST_N,
	// APB side.
	input wire logic         I_PSEL,
	input wire logic         I_PENABLE,
	input wire logic         I_PWRITE,
	input wire logic [7:0]   I_PADDR,
	input wire logic [31:0]  I_PWDATA,
	input wire logic         O_PREADY,
	input wire logic         O_PSLVERR,
	// Front end and status.
	input wire atc_front_t   O_FRONT,
	input wire logic         O_RUNNING
);
	logic       wr_acc;
	logic       wr_cfg;
	logic       wr_cmd;
	logic       start_req;
	logic [1:0] gnd_w;
	logic [3:0] rng_w;

	// Decoded write strobes; configuration writes only land while idle.
	assign wr_acc    = I_PSEL && I_PENABLE && I_PWRITE;
	assign wr_cfg    = wr_acc && !O_RUNNING;
	assign wr_cmd    = wr_acc && I_PADDR == ATC_OFS_CMD;
	assign start_req = wr_cmd && I_PWDATA[ATC_CMD_START];
	assign gnd_w     = I_PWDATA[5:4];
	assign rng_w     = I_PWDATA[11:8];

	default clocking cb @(posedge I_CLOCK); endclocking
	default disable iff (!I_RST_N);

	property p_apb_ok;
		O_PREADY && !O_PSLVERR;
	endproperty
	a_apb_ok: assert property (p_apb_ok) else $error("apb answer not zero wait");
	property p_start_runs;
		start_req && !I_PWDATA[ATC_CMD_STOP] && !O_RUNNING |=> O_RUNNING;
	endproperty
	a_start_runs: assert property (p_start_runs) else $error("start did not run");
	property p_run_cause;
		$rose(O_RUNNING) |-> $past(start_req);
	endproperty
	a_run_cause: assert property (p_run_cause) else $error("run without start");
	property p_stop;
		wr_cmd && I_PWDATA[ATC_CMD_STOP] |=> !O_RUNNING;
	endproperty
	a_stop: assert property (p_stop) else $error("stop ignored");
	property p_quiet;
		!O_RUNNING ##1 !O_RUNNING |-> !O_FRONT.sample && !O_FRONT.store;
	endproperty
	a_quiet: assert property (p_quiet) else $error("sample while idle");
	property p_ground;
		wr_cfg && I_PADDR == ATC_OFS_CONFIG |=> O_FRONT.ground == $past(gnd_w);
	endproperty
	a_ground: assert property (p_ground) else $error("grounding not applied");
	property p_rng_all;
		wr_cfg && I_PADDR == ATC_OFS_RANGE && I_PWDATA[7:0] == ATC_ALL_CHANNELS
		|=> {O_FRONT.range0, O_FRONT.range1, O_FRONT.range2, O_FRONT.range3} == {4{$past(rng_w)}};
	endproperty
	a_rng_all: assert property (p_rng_all) else $error("range to all failed");
	property p_rng_one;
		wr_cfg && I_PADDR == ATC_OFS_RANGE && I_PWDATA[7:0] == 8'h02
		|=> O_FRONT.range2 == $past(rng_w) && $stable(O_FRONT.range0);
	endproperty
	a_rng_one: assert property (p_rng_one) else $error("single range failed");
	property p_reset;
		$rose(I_RST_N) |-> O_FRONT.ground == ATC_GND_RSE && !O_RUNNING
		&& {O_FRONT.range0, O_FRONT.range1, O_FRONT.range2, O_FRONT.range3} == {4{ATC_RANGE_B10V}};
	endproperty
	a_reset: assert property (p_reset) else $error("wrong reset defaults");
endmodule
bind atc_trigger_ctrl atc_trigger_ctrl_assertions u_chk (
	.I_CLOCK   (I_CLOCK),
	.I_RST_N   (I_RST_N),
	.I_PSEL    (I_PSEL),
	.I_PENABLE (I_PENABLE),
	.I_PWRITE  (I_PWRITE),
	.I_PADDR   (I_PADDR),
	.I_PWDATA  (I_PWDATA),
	.O_PREADY  (O_PREADY),
	.O_PSLVERR (O_PSLVERR),
	.O_FRONT   (O_FRONT),
	.O_RUNNING (O_RUNNING)
);

// [verification/atc_trigger_ctrl_tb.sv]
/*
 * Self-checking bench for the acquisition trigger controller.
 * Assumes the far-side model and the bound checker are compiled with it.
 */
`timescale 1ns/1ns
module atc_trigger_ctrl_tb;
	import atc_pkg::*;
	logic        clock;
	logic        rst_n;
	logic        psel;
	logic        pen;
	logic        pwr;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic [31:0] q;
	logic        pready;
	logic        pslverr;
	logic        running;
	atc_pins_t   pins;
	atc_front_t  front;
	int          failures;
	int          checks_done;
	int          stores;
	int          n;

	atc_trigger_ctrl u_dut (
		.I_CLOCK   (clock),
		.I_RST_N   (rst_n),
		.I_PSEL    (psel),
		.I_PENABLE (pen),
		.I_PWRITE  (pwr),
		.I_PADDR   (paddr),
		.I_PWDATA  (pwdata),
		.O_PRDATA  (prdata),
		.O_PREADY  (pready),
		.O_PSLVERR (pslverr),
		.I_PINS    (pins),
		.O_FRONT   (front),
		.O_RUNNING (running)
	);
	atc_far_model u_far (
		.i_clock (clock),
		.o_pins  (pins)
	);

	// Free-running 250 MHz clock.
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	// Counts store pulses; tests zero it away from the clock edge.
	always @(posedge clock) begin
		if (front.store === 1'b1)
			stores++;
	end

	// One APB transfer; the slave decides how long the access phase lasts.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		pen <= 1'b1;
		// Only the watchdog ends a slave that never answers.
		do begin
			@(posedge clock);
		end while (pready !== 1'b1);
		q = prdata;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(q, exp);
	endtask
	// Looks between edges, then lets the last store pulse be counted before returning.
	task automatic wait_idle();
		n = 0;
		while (running !== 1'b0 && n < 200) begin
			@(negedge clock);
			n++;
		end
		if (running !== 1'b0)
			failures++;
		@(negedge clock);
	endtask
	// Source 0 is the software command; the others pulse their pin.
	task automatic fire(input int s);
		@(negedge clock);
		stores = 0;
		if (s == 0)
			wr(ATC_OFS_CMD, 32'h4);
		else
			u_far.pulse(3 - s);
	endtask
	task automatic go(input logic [31:0] cfg, trg, post, total);
		wr(ATC_OFS_CONFIG, cfg);
		wr(ATC_OFS_TRIG, trg);
		wr(ATC_OFS_POSTCNT, post);
		wr(ATC_OFS_TOTAL, total);
		wr(ATC_OFS_CMD, 32'h1);
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Cuts a hung run short; the sequence needs well under a thousand cycles.
	initial begin
		repeat (20000) @(posedge clock);
		failures++;
		end_sim();
	end

	// Main sequence.
	initial begin
		rst_n = 1'b0;
		psel = 1'b0;
		pen = 1'b0;
		pwr = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		failures = 0;
		checks_done = 0;
		stores = 0;
		repeat (6) @(posedge clock);
		rst_n <= 1'b1;
		rdchk(ATC_OFS_STATUS, 32'h1);
		rdchk(ATC_OFS_CONFIG, 32'h0);
		rdchk(ATC_OFS_TRIG, 32'h0);
		wr(ATC_OFS_RANGERD, 32'h3);
		rdchk(ATC_OFS_RANGE, 32'h0);
		rdchk(8'h30, 32'h0);
		for (int i = 0; i < 4; i++) begin
			wr(ATC_OFS_CONFIG, 32'((i % 3) << 4 | i << 2 | i));
			rdchk(ATC_OFS_CONFIG, 32'((i % 3) << 4 | i << 2 | i));
		end
		wr(ATC_OFS_RANGE, 32'h0502);
		wr(ATC_OFS_RANGERD, 32'h2);
		rdchk(ATC_OFS_RANGE, 32'h5);
		wr(ATC_OFS_RANGERD, 32'h0);
		rdchk(ATC_OFS_RANGE, 32'h0);
		wr(ATC_OFS_RANGE, 32'h03ff);
		wr(ATC_OFS_RANGERD, 32'h1);
		rdchk(ATC_OFS_RANGE, 32'h3);
		// Each trigger source in post mode gives one segment of three samples.
		for (int s = 0; s < 4; s++) begin
			go(32'h0, 32'(s), 32'h3, 32'h4);
			fire(s);
			wait_idle();
			chk(32'(stores), 32'h3);
			rdchk(ATC_OFS_STATUS, 32'h00010041);
		end
		// A count of two ends the run; zero keeps accepting until stopped.
		for (int c = 0; c < 2; c++) begin
			wr(ATC_OFS_RETRIG, 32'(2 - 2 * c));
			go(32'h0, 32'h22, 32'h2, 32'h2);
			for (int t = 0; t < 3; t++) begin
				fire(2);
				repeat (10) @(posedge clock);
				chk(32'(stores), (c == 0 && t == 2) ? 32'h0 : 32'h2);
			end
			chk({31'h0, running}, 32'(c));
		end
		wr(ATC_OFS_TRIG, 32'h0c);
		wr(ATC_OFS_CMD, 32'h2);
		repeat (2) @(posedge clock);
		chk({31'h0, running}, 32'h0);
		rdchk(ATC_OFS_TRIG, 32'h22);
		// The rising edge is ignored when the falling edge is chosen.
		go(32'h0, 32'h82, 32'h2, 32'h2);
		@(negedge clock);
		stores = 0;
		u_far.level(1, 1'b1);
		repeat (10) @(posedge clock);
		chk(32'(stores), 32'h0);
		u_far.level(1, 1'b0);
		wait_idle();
		chk(32'(stores), 32'h2);
		// Delay mode in ticks shows the delay state, then takes the total count.
		go(32'h0, 32'h04, 32'h3, 32'h4);
		fire(0);
		apb(1'b0, ATC_OFS_STATUS, 32'h0);
		chk({27'h0, q[4:0]}, 32'h8);
		wait_idle();
		chk(32'(stores), 32'h4);
		// Delay in samples of aux input 0, then in ticks of timer 0 output.
		for (int k = 0; k < 2; k++) begin
			go(k ? 32'h8 : 32'h1, k ? 32'h04 : 32'h14, 32'h1, 32'h2);
			fire(0);
			repeat (20) @(posedge clock);
			chk(32'(stores), 32'h0);
			for (n = 0; n < 12 && running === 1'b1; n++)
				u_far.pulse(k ? 4 : 7);
			chk(32'(stores), 32'h2);
		end
		// Pre mode ignores a trigger until the pretrigger counter expires.
		wr(ATC_OFS_PRECNT, 32'd20);
		go(32'h0, 32'h48, 32'h0, 32'd20);
		fire(0);
		repeat (30) @(posedge clock);
		apb(1'b0, ATC_OFS_STATUS, 32'h0);
		chk({27'h0, q[4:0]}, 32'h4);
		chk(32'(stores > 0), 32'h1);
		fire(0);
		repeat (4) @(posedge clock);
		chk({31'h0, running}, 32'h0);
		// Middle mode takes the post count after the trigger, then stops.
		wr(ATC_OFS_PRECNT, 32'd4);
		go(32'h0, 32'h4c, 32'd6, 32'd10);
		repeat (10) @(posedge clock);
		fire(0);
		// The pre-trigger fill up to the trigger edge is not part of the post count.
		repeat (3) @(negedge clock);
		stores = 0;
		wait_idle();
		chk(32'(stores), 32'd6);
		end_sim();
	end
endmodule
